// *** verif/fwsr_flash_model.sv ***
/*
 * Behavioural byte-wide flash that reports embedded operation status.
 * Assumes the bench starts an operation through begin_op; kinds are
 * 0 array, 1 program, 2 erase, 3 program running past its limit.
 */
`timescale 1ns/1ps
`default_nettype none
module fwsr_flash_model (
   input wire logic [19:0] addr_in,
   input wire logic [7:0] dq_in,
   input wire logic ce_n_in,
   input wire logic oe_n_in,
   input wire logic we_n_in,
   output logic [7:0] dq_out,
   output logic rb_low_out
);
   logic [1:0] mode = 2'h0;
   int rem = 0;
   logic tog = 1'b0;
   logic stog = 1'b0;
   logic susp = 1'b0;
   logic [7:0] arr = 8'h00;
   logic [7:0] last = 8'h00;
   logic [7:0] stat;
   logic [7:0] wr_data = 8'h00;
   logic [19:0] wr_addr = 20'h0_0000;
   wire rd_act = !ce_n_in && !oe_n_in;
   wire wr_act = !ce_n_in && !we_n_in;

   task automatic begin_op(input logic [1:0] k, input int r,
                           input logic [7:0] a);
      mode = k;
      rem = r;
      arr = a;
      tog = 1'b0;
      stog = 1'b0;
      susp = 1'b0;
      wr_data = 8'h00;
      wr_addr = 20'h0_0000;
   endtask

   // Puts a running erase into the suspended state.
   task automatic suspend();
      susp = 1'b1;
   endtask

   always_comb begin
      case (mode)
         2'h1: stat = {~arr[7], tog, 1'b0, arr[4:0]};
         2'h2: stat = {susp, tog, 3'h0, stog, 2'h0};
         2'h3: stat = {~arr[7], tog, 1'b1, arr[4:0]};
         default: stat = arr;
      endcase
   end

   // A released bus shows the inverse of the last byte, never a hold.
   assign dq_out = rd_act ? stat : ~last;
   assign rb_low_out = (mode != 2'h0) && !(mode == 2'h2 && susp);

   always @(negedge rd_act) begin
      last = stat;
      if (mode != 2'h0) begin
         stog = ~stog;
         if (!susp) begin
            tog = ~tog;
            rem = rem - 1;
            if (rem == 0) begin
               mode = 2'h0;
            end
         end
      end
   end

   always @(posedge wr_act) begin
      #2;
      wr_addr = addr_in;
      wr_data = dq_in;
   end

   always @(negedge wr_act) begin
      if (wr_data == 8'hF0) begin
         mode = 2'h0;
      end
   end
endmodule
`default_nettype wire

// *** verif/fwsr_poller_monitor.sv ***
/*
 * Concurrent checks on the flash status poller's ports.
 * Assumes a single clock domain and the strobe timing of the package.
 */
`timescale 1ns/1ps
`default_nettype none
module fwsr_poller_monitor #(
   parameter int ADDR_W = 20
) (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic reg_rd_in,
   input wire logic [31:0] reg_rdata_out,
   input wire logic [ADDR_W-1:0] fl_addr_out,
   input wire logic [7:0] fl_dq_out,
   input wire logic fl_dq_oe_out,
   input wire logic fl_ce_n_out,
   input wire logic fl_oe_n_out,
   input wire logic fl_we_n_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);

   a_rdata_idle_zero: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
      else $error("read data not zero outside a read answer");
   a_read_pulse_len: assert property ($fell(fl_oe_n_out) |-> ##11 !fl_oe_n_out ##1 fl_oe_n_out)
      else $error("read strobe width wrong");
   a_read_recovery: assert property ($rose(fl_oe_n_out) |-> fl_oe_n_out[*4])
      else $error("read recovery too short");
   a_ce_frames_oe: assert property (!fl_oe_n_out |-> !fl_ce_n_out)
      else $error("output enable low without chip select");
   a_no_strobe_clash: assert property (!(!fl_oe_n_out && !fl_we_n_out))
      else $error("read and write strobes low together");
   a_drive_only_write: assert property (fl_dq_oe_out |-> fl_oe_n_out && fl_dq_out == 8'hF0)
      else $error("data bus driven during read or with wrong command");
   a_write_pulse_len: assert property ($fell(fl_we_n_out) |-> (!fl_we_n_out && fl_dq_oe_out)[*8] ##1 fl_we_n_out)
      else $error("write strobe width or data drive wrong");
   a_addr_held_read: assert property (!fl_oe_n_out && !$past(fl_oe_n_out) |-> $stable(fl_addr_out))
      else $error("address moved inside a read cycle");
endmodule
bind fwsr_poller fwsr_poller_monitor #(.ADDR_W(ADDR_W)) u_mon (
   .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out), .fl_addr_out(fl_addr_out),
   .fl_dq_out(fl_dq_out), .fl_dq_oe_out(fl_dq_oe_out),
   .fl_ce_n_out(fl_ce_n_out), .fl_oe_n_out(fl_oe_n_out),
   .fl_we_n_out(fl_we_n_out));
`default_nettype wire

// *** verif/testbench.sv ***
/*
 * Self-checking bench for the flash status poller against a flash model.
 * Assumes a 200 MHz clock and the register map of the design package.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam logic [19:0] POLL_ADDR = 20'h3_0005;
   logic ref_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [3:0] reg_addr_in = 4'h0;
   logic [31:0] reg_wdata_in = 32'h0;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic [31:0] reg_rdata_out;
   logic [19:0] fl_addr_out;
   logic [7:0] fl_dq_out;
   logic [7:0] m_dq;
   logic fl_dq_oe_out, fl_ce_n_out, fl_oe_n_out, fl_we_n_out, rb_low;
   int error_cnt = 0;
   int n_checks = 0;
   int cycles = 0;
   wire [7:0] dq_bus = fl_dq_oe_out ? fl_dq_out : m_dq;
   // Pulled-up open-drain busy line.
   wire ready_busy = !rb_low;

   always #2.5 ref_clk_in = ~ref_clk_in;

   fwsr_poller #(.ADDR_W(20)) u_fwsr_poller (
      .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .fl_addr_out(fl_addr_out),
      .fl_dq_in(dq_bus), .fl_dq_out(fl_dq_out),
      .fl_dq_oe_out(fl_dq_oe_out), .fl_ce_n_out(fl_ce_n_out),
      .fl_oe_n_out(fl_oe_n_out), .fl_we_n_out(fl_we_n_out),
      .ready_busy_in(ready_busy));

   fwsr_flash_model u_flash_model (
      .addr_in(fl_addr_out), .dq_in(dq_bus), .ce_n_in(fl_ce_n_out),
      .oe_n_in(fl_oe_n_out), .we_n_in(fl_we_n_out), .dq_out(m_dq),
      .rb_low_out(rb_low));

   task automatic print_verdict();
      if (error_cnt == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] exp,
                        input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
         error_cnt++;
      end
   endtask

   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge ref_clk_in);
      reg_wr_in <= 1'b0;
   endtask

   task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge ref_clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge ref_clk_in);
      reg_rd_in <= 1'b0;
      #1 d = reg_rdata_out;
   endtask

   task automatic run_case(input logic pmode, input logic [1:0] kind,
                           input int reads, input logic [7:0] arr,
                           input logic fail, input logic sus);
      logic [31:0] s;
      logic [31:0] d;
      logic [31:0] exp;
      int i;
      u_flash_model.begin_op(kind, reads, arr);
      if (sus) begin
         u_flash_model.suspend();
      end
      reg_write(fwsr_pkg::REG_ADDR, {12'h000, POLL_ADDR});
      reg_write(fwsr_pkg::REG_CTRL, {16'h0000, arr, 6'h00, pmode, 1'b1});
      reg_read(fwsr_pkg::REG_STAT, s);
      check("busy", 32'h1, {31'h0, s[0]});
      for (i = 0; i < 3000 && s[0] !== 1'b0; i++) begin
         reg_read(fwsr_pkg::REG_STAT, s);
      end
      exp = (32'h1 << fwsr_pkg::STAT_DONE_POS) |
            (32'h1 << fwsr_pkg::STAT_RDY_POS) |
            ({31'h0, fail} << fwsr_pkg::STAT_FAIL_POS);
      check("stat", exp, s);
      if (fail) begin
         check("cmd", {24'h0, fwsr_pkg::CMD_RESET},
               {24'h0, u_flash_model.wr_data});
         check("cmd addr", {12'h0, POLL_ADDR},
               {12'h0, u_flash_model.wr_addr});
      end else begin
         reg_read(fwsr_pkg::REG_DATA, d);
         check("data", {24'h0, arr}, d);
      end
   endtask

   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 40000) begin
         $display("MISMATCH timeout expected done seen hang");
         error_cnt++;
         print_verdict();
      end
   end

   initial begin
      logic [31:0] r;
      repeat (6) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      reg_read(fwsr_pkg::REG_STAT, r);
      check("stat reset", {24'h0, fwsr_pkg::STAT_RESET} |
            (32'h1 << fwsr_pkg::STAT_RDY_POS), r);
      reg_read(4'h9, r);
      check("unmapped", 32'h0, r);
      run_case(1'b0, 2'h1, 6, 8'hA5, 1'b0, 1'b0);
      run_case(1'b0, 2'h1, 1, 8'h3C, 1'b0, 1'b0);
      run_case(1'b1, 2'h1, 4, 8'h5A, 1'b0, 1'b0);
      run_case(1'b1, 2'h2, 5, 8'hFF, 1'b0, 1'b0);
      run_case(1'b1, 2'h2, 50, 8'h80, 1'b0, 1'b1);
      run_case(1'b0, 2'h2, 50, 8'h80, 1'b0, 1'b1);
      run_case(1'b0, 2'h3, 2, 8'h40, 1'b0, 1'b0);
      run_case(1'b0, 2'h3, 100000, 8'h81, 1'b1, 1'b0);
      run_case(1'b1, 2'h3, 100000, 8'h81, 1'b1, 1'b0);
      u_flash_model.begin_op(2'h1, 12, 8'h66);
      reg_write(fwsr_pkg::REG_CTRL, 32'h0000_6601);
      repeat (40) @(posedge ref_clk_in);
      reg_write(fwsr_pkg::REG_CTRL, 32'h0000_0004);
      reg_read(fwsr_pkg::REG_STAT, r);
      check("abort", 32'h1 << fwsr_pkg::STAT_ABORT_POS, r);
      run_case(1'b0, 2'h2, 3, 8'hFF, 1'b0, 1'b0);
      print_verdict();
   end
endmodule
`default_nettype wire

// *** verilog/fwsr_bus_cycle.sv ***
/*
 * One flash bus cycle: a read framed by output enable, or a write framed
 * by write enable, with the chip select held low for the strobe pulse only.
 * Assumes one request at a time, taken only while ready_out is high.
 */
`timescale 1ns/1ps
`default_nettype none
module fwsr_bus_cycle #(
   parameter int ADDR_W = 20
) (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic req_in,
   input wire logic write_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic [7:0] dq_in,
   output logic ready_out,
   output logic done_out,
   output logic [7:0] rdata_out,
   output logic [ADDR_W-1:0] fl_addr_out,
   output logic [7:0] dq_out,
   output logic dq_oe_out,
   output logic fl_ce_n_out,
   output logic fl_oe_n_out,
   output logic fl_we_n_out
);
   typedef enum logic [1:0] {
      BC_IDLE = 2'b00,
      BC_PULSE = 2'b01,
      BC_RECOVER = 2'b11
   } fwsr_bc_state_t;

   fwsr_bc_state_t state;
   logic is_write;
   logic [7:0] count;

   assign ready_out = (state == BC_IDLE);

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state <= BC_IDLE;
         count <= 8'h00;
         is_write <= 1'b0;
      end else begin
         unique case (state)
            BC_IDLE: begin
               if (req_in) begin
                  state <= BC_PULSE;
                  is_write <= write_in;
                  count <= write_in ?
                     8'(fwsr_pkg::WRITE_PULSE_CYC - 1) :
                     8'(fwsr_pkg::READ_PULSE_CYC - 1);
               end
            end
            BC_PULSE: begin
               if (count == 8'h00) begin
                  state <= BC_RECOVER;
                  count <= 8'(fwsr_pkg::READ_RECOVER_CYC - 1);
               end else begin
                  count <= count - 8'h01;
               end
            end
            BC_RECOVER: begin
               if (count == 8'h00) begin
                  state <= BC_IDLE;
               end else begin
                  count <= count - 8'h01;
               end
            end
            default: state <= BC_IDLE;
         endcase
      end
   end

   // Pins come from flops; the strobe rises as the pulse ends.
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fl_addr_out <= '0;
         dq_out <= 8'h00;
         dq_oe_out <= 1'b0;
         fl_ce_n_out <= 1'b1;
         fl_oe_n_out <= 1'b1;
         fl_we_n_out <= 1'b1;
      end else if (state == BC_IDLE && req_in) begin
         fl_addr_out <= addr_in;
         dq_out <= wdata_in;
         dq_oe_out <= write_in;
         fl_ce_n_out <= 1'b0;
         fl_oe_n_out <= write_in;
         fl_we_n_out <= !write_in;
      end else if (state == BC_PULSE && count == 8'h00) begin
         fl_ce_n_out <= 1'b1;
         fl_oe_n_out <= 1'b1;
         fl_we_n_out <= 1'b1;
      end else if (state == BC_RECOVER && count == 8'h00) begin
         dq_oe_out <= 1'b0;
      end
   end

   // Read data are sampled at the end of the strobe pulse.
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_out <= 8'h00;
         done_out <= 1'b0;
      end else begin
         done_out <= (state == BC_PULSE && count == 8'h00);
         if (state == BC_PULSE && count == 8'h00 && !is_write) begin
            rdata_out <= dq_in;
         end
      end
   end
endmodule
`default_nettype wire

// *** verilog/fwsr_pkg.sv ***
/*
 * Shared constants for the flash status poller: data bit positions,
 * bus cycle timing, command values and result codes.
 * Assumes a 200 MHz controller clock and a byte-wide asynchronous flash.
 */
package fwsr_pkg;
   localparam int CLK_MHZ = 200;
   // Bit positions inside the status byte.
   localparam int POLL_BIT_POS = 7;
   localparam int GTOG_BIT_POS = 6;
   localparam int FAIL_BIT_POS = 5;
   localparam int STOG_BIT_POS = 2;
   // Read cycle strobe width and recovery, in ns.
   localparam int READ_PULSE_NS = 60;
   localparam int READ_RECOVER_NS = 20;
   localparam int READ_PULSE_CYC = (READ_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int READ_RECOVER_CYC =
      (READ_RECOVER_NS * CLK_MHZ + 999) / 1000;
   // Write strobe width for the reset command, in ns.
   localparam int WRITE_PULSE_NS = 40;
   localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] CMD_RESET = 8'hF0;
   // Software register offsets.
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_ADDR = 4'h1;
   localparam logic [3:0] REG_STAT = 4'h2;
   localparam logic [3:0] REG_DATA = 4'h3;
   // Control register fields.
   localparam int CTRL_START_POS = 0;
   localparam int CTRL_MODE_POS = 1;
   localparam int CTRL_ABORT_POS = 2;
   // Status register fields.
   localparam int STAT_BUSY_POS = 0;
   localparam int STAT_DONE_POS = 1;
   localparam int STAT_FAIL_POS = 2;
   localparam int STAT_RDY_POS = 3;
   localparam int STAT_ABORT_POS = 4;
   localparam logic [7:0] STAT_RESET = 8'h00;
endpackage

// *** verilog/fwsr_poller.sv ***
/*
 * Host-side status poller for a byte-wide flash running an embedded
 * program or erase. Software starts a poll through a small register port;
 * the block reads status, decides completion or failure, and on failure
 * writes the reset command.
 * Assumes the flash data bus is sampled late enough in each read strobe,
 * and that the command sequence was already written by other logic.
 */
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module fwsr_poller #(
   parameter int ADDR_W = 20
) (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic [3:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   output logic [ADDR_W-1:0] fl_addr_out,
   input wire logic [7:0] fl_dq_in,
   output logic [7:0] fl_dq_out,
   output logic fl_dq_oe_out,
   output logic fl_ce_n_out,
   output logic fl_oe_n_out,
   output logic fl_we_n_out,
   input wire logic ready_busy_in
);
   typedef enum logic [3:0] {
      P_IDLE = 4'b0000,
      P_FIRST = 4'b0001,
      P_SECOND = 4'b0011,
      P_CHECK = 4'b0010,
      P_RECHECK = 4'b0110,
      P_FINAL = 4'b0111,
      P_RESET = 4'b0101,
      P_WAIT = 4'b0100,
      P_DONE = 4'b1100
   } fwsr_poll_state_t;

   fwsr_poll_state_t state;
   logic mode_poll;
   logic [ADDR_W-1:0] poll_addr;
   logic [7:0] expect_data;
   logic [7:0] prev_byte;
   logic [7:0] data_reg;
   logic done_flag;
   logic fail_flag;
   logic abort_flag;
   logic ready_sync;
   logic cyc_req;
   logic cyc_write;
   logic cyc_ready;
   logic cyc_done;
   logic [7:0] cyc_rdata;
   logic start_req;
   logic abort_req;
   logic toggled;
   logic poll_true;
   logic fail_seen;

   assign start_req = reg_wr_in && reg_addr_in == fwsr_pkg::REG_CTRL &&
      reg_wdata_in[fwsr_pkg::CTRL_START_POS];
   assign abort_req = reg_wr_in && reg_addr_in == fwsr_pkg::REG_CTRL &&
      reg_wdata_in[fwsr_pkg::CTRL_ABORT_POS];

   // open-drain sampling: the pin is pulled up and read as a level.
   fwsr_sync3 u_rb_sync (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .pin_in(ready_busy_in),
      .reset_val_in(1'b1),
      .level_out(ready_sync)
   );

   fwsr_bus_cycle #(
      .ADDR_W(ADDR_W)
   ) u_cycle (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .req_in(cyc_req),
      .write_in(cyc_write),
      .addr_in(poll_addr),
      .wdata_in(fwsr_pkg::CMD_RESET),
      .dq_in(fl_dq_in),
      .ready_out(cyc_ready),
      .done_out(cyc_done),
      .rdata_out(cyc_rdata),
      .fl_addr_out(fl_addr_out),
      .dq_out(fl_dq_out),
      .dq_oe_out(fl_dq_oe_out),
      .fl_ce_n_out(fl_ce_n_out),
      .fl_oe_n_out(fl_oe_n_out),
      .fl_we_n_out(fl_we_n_out)
   );

   // toggle compare: global bit changed between two reads.
   assign toggled = (cyc_rdata[fwsr_pkg::GTOG_BIT_POS] !=
      prev_byte[fwsr_pkg::GTOG_BIT_POS]);
   // poll compare: bit seven equals the expected true datum.
   assign poll_true = (cyc_rdata[fwsr_pkg::POLL_BIT_POS] ==
      expect_data[fwsr_pkg::POLL_BIT_POS]);
   // failure flag seen on the status byte.
   assign fail_seen = cyc_rdata[fwsr_pkg::FAIL_BIT_POS];

   // A bus cycle is requested whenever a read or write state is entered.
   always_comb begin
      cyc_req = 1'b0;
      cyc_write = 1'b0;
      if (cyc_ready && !abort_req) begin
         unique case (state)
            P_FIRST, P_SECOND, P_RECHECK, P_FINAL: cyc_req = 1'b1;
            P_RESET: begin
               cyc_req = 1'b1;
               cyc_write = 1'b1;
            end
            default: cyc_req = 1'b0;
         endcase
      end
   end

   // Main sequencing. Each issued cycle moves the FSM to a waiting
   // sub-step tracked by the pending flag.
   logic pending;

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pending <= 1'b0;
      end else if (abort_req) begin
         // A cycle still in flight finishes unclaimed after an abort.
         pending <= 1'b0;
      end else if (cyc_req) begin
         pending <= 1'b1;
      end else if (cyc_done) begin
         pending <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state <= P_IDLE;
      end else if (abort_req && state != P_IDLE) begin
         // restart loop: leaving the loop drops all progress.
         state <= P_IDLE;
      end else begin
         unique case (state)
            P_IDLE: begin
               if (start_req) begin
                  state <= P_FIRST;
               end
            end
            P_FIRST: begin
               if (pending && cyc_done) begin
                  state <= P_SECOND;
               end
            end
            P_SECOND: begin
               if (pending && cyc_done) begin
                  state <= P_CHECK;
               end
            end
            P_CHECK: begin
               // double read: unchanged toggle, or in poll mode a true bit seven, means finished.
               if (mode_poll ? poll_true : !toggled) begin
                  state <= P_FINAL;
               end else if (fail_seen) begin
                  // recheck once more after the fail bit.
                  state <= P_RECHECK;
               end else begin
                  state <= P_SECOND;
               end
            end
            P_RECHECK: begin
               if (pending && cyc_done) begin
                  // re-read poll or toggle bit, by mode, after fail bit high.
                  if (mode_poll ? poll_true : !toggled) begin
                     state <= P_FINAL;
                  end else begin
                     state <= P_RESET;
                  end
               end
            end
            P_FINAL: begin
               // true data taken on the read after the status read.
               if (pending && cyc_done) begin
                  state <= P_DONE;
               end
            end
            P_RESET: begin
               if (pending && cyc_done) begin
                  state <= P_WAIT;
               end
            end
            P_WAIT: begin
               if (ready_sync) begin
                  state <= P_DONE;
               end
            end
            P_DONE: state <= P_IDLE;
            default: state <= P_IDLE;
         endcase
      end
   end

   // Holds the older byte of the compared pair: it is latched as the next
   // read is issued, while the read data still show the last byte.
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prev_byte <= 8'h00;
      end else if (cyc_req && !cyc_write) begin
         prev_byte <= cyc_rdata;
      end
   end

   // Configuration written by software.
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode_poll <= 1'b0;
         poll_addr <= '0;
         expect_data <= 8'h00;
      end else if (reg_wr_in && state == P_IDLE) begin
         if (reg_addr_in == fwsr_pkg::REG_CTRL) begin
            mode_poll <= reg_wdata_in[fwsr_pkg::CTRL_MODE_POS];
            expect_data <= reg_wdata_in[15:8];
         end
         // poll address chosen inside an erasing sector.
         if (reg_addr_in == fwsr_pkg::REG_ADDR) begin
            poll_addr <= reg_wdata_in[ADDR_W-1:0];
         end
      end
   end

   // Result flags; a new start clears them, completion, failure or abort sets them.
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         done_flag <= 1'b0;
         fail_flag <= 1'b0;
         abort_flag <= 1'b0;
         data_reg <= 8'h00;
      end else begin
         if (state == P_DONE) begin
            done_flag <= 1'b1;
         end else if (start_req && state == P_IDLE) begin
            done_flag <= 1'b0;
         end
         if (state == P_RECHECK && pending && cyc_done &&
               !(mode_poll ? poll_true : !toggled)) begin
            fail_flag <= 1'b1;
         end else if (start_req && state == P_IDLE) begin
            fail_flag <= 1'b0;
         end
         if (abort_req && state != P_IDLE) begin
            abort_flag <= 1'b1;
         end else if (start_req && state == P_IDLE) begin
            abort_flag <= 1'b0;
         end
         if (state == P_FINAL && pending && cyc_done) begin
            data_reg <= cyc_rdata;
         end
      end
   end

   // Register read port, data in the cycle after the strobe.
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= 32'h0000_0000;
      end else if (reg_rd_in) begin
         unique case (reg_addr_in)
            fwsr_pkg::REG_CTRL: reg_rdata_out <= {16'h0000, expect_data,
               6'h00, mode_poll, 1'b0};
            fwsr_pkg::REG_ADDR: reg_rdata_out <= 32'(poll_addr);
            fwsr_pkg::REG_STAT: reg_rdata_out <= {27'h0000000,
               abort_flag, ready_sync, fail_flag, done_flag,
               (state != P_IDLE)};
            fwsr_pkg::REG_DATA: reg_rdata_out <= {24'h000000, data_reg};
            default: reg_rdata_out <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata_out <= 32'h0000_0000;
      end
   end
endmodule
`default_nettype wire

// *** verilog/fwsr_sync3.sv ***
/*
 * Three flip-flop synchroniser for one pin level.
 * Assumes the input is asynchronous to the clock; the output changes only
 * when the second and third stages agree.
 */
`timescale 1ns/1ps
`default_nettype none
module fwsr_sync3 (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic pin_in,
   input wire logic reset_val_in,
   output logic level_out
);
   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1 <= 1'b1;
         s2 <= 1'b1;
         s3 <= 1'b1;
      end else begin
         s1 <= pin_in;
         s2 <= s1;
         s3 <= s2;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         level_out <= 1'b1;
      end else if (s2 == s3) begin
         level_out <= s3;
      end
   end
endmodule
`default_nettype wire
